// File: core/ecrp_defines.vh
// constants for the external configuration register port
`ifndef ECRP_DEFINES_VH
`define ECRP_DEFINES_VH

// =====================================================
// field widths
`define ECRP_REG_W        10
`define ECRP_FUNC_W       8
`define ECRP_DATA_W       32
`define ECRP_BE_W         4
`define ECRP_ADDR_W       12

// =====================================================
// forwarding windows, compared on byte address {reg, 2'b00}
`define ECRP_LEG_LO       12'h0B0
`define ECRP_LEG_HI       12'h0BF
`define ECRP_EXT_LO       12'hE80
`define ECRP_EXT_HI       12'hFFF

// =====================================================
// read response timeout, in user clock cycles
`define ECRP_RD_TIMEOUT   262144
`define ECRP_CNT_W        19

// =====================================================
// controller states
`define ECRP_ST_IDLE      1'b0
`define ECRP_ST_WAIT      1'b1

// =====================================================
// reset values
`define ECRP_ZERO_DATA    32'h0000_0000
`define ECRP_ZERO_REG     10'h000
`define ECRP_ZERO_FUNC    8'h00
`define ECRP_ZERO_BE      4'h0
`define ECRP_ZERO_CNT     19'h0_0000

`endif

// File: core/ecrp_port.v
// external configuration register port: forwards link config accesses to user logic
`timescale 1ns/1ps
`include "ecrp_defines.vh"

module ecrp_port #(
   parameter TIMEOUT_CYCLES = `ECRP_RD_TIMEOUT
) (
   // =====================================================
   // clock and fundamental reset
   input  wire                      ref_clk,
   input  wire                      arst_n,

   // =====================================================
   // option strap
   input  wire                      ext_space_en,

   // =====================================================
   // configuration requests from the link
   input  wire                      link_req_valid,
   input  wire                      link_req_write,
   input  wire [`ECRP_REG_W-1:0]    link_req_reg,
   input  wire [`ECRP_FUNC_W-1:0]   link_req_func,
   input  wire [`ECRP_DATA_W-1:0]   link_req_data,
   input  wire [`ECRP_BE_W-1:0]     link_req_be,
   output reg                       link_req_ready,

   // =====================================================
   // read completion back to the link
   output reg                       link_cpl_valid,
   output reg  [`ECRP_DATA_W-1:0]   link_cpl_data,
   output reg                       link_cpl_auto,

   // =====================================================
   // user side
   output reg                       user_reset,
   output reg                       read_received,
   output reg                       write_received,
   output reg  [`ECRP_REG_W-1:0]    register_number,
   output reg  [`ECRP_FUNC_W-1:0]   function_number,
   output reg  [`ECRP_DATA_W-1:0]   write_data,
   output reg  [`ECRP_BE_W-1:0]     write_byte_enable,
   input  wire [`ECRP_DATA_W-1:0]   read_data,
   input  wire                      read_data_valid
);

   // =====================================================
   // constants
   // cut to the counter width on purpose; the last count fits while TIMEOUT_CYCLES is at most 524288
   localparam integer           TIMEOUT_LAST_I = TIMEOUT_CYCLES - 1;
   localparam [`ECRP_CNT_W-1:0] TIMEOUT_LAST   = TIMEOUT_LAST_I[`ECRP_CNT_W-1:0];

   // controller states
   localparam [0:0]             ST_IDLE        = `ECRP_ST_IDLE;
   localparam [0:0]             ST_WAIT        = `ECRP_ST_WAIT;

   // =====================================================
   // declarations
   reg                       state;
   reg                       next_state;
   reg [`ECRP_CNT_W-1:0]     wait_cnt;
   reg [`ECRP_CNT_W-1:0]     next_wait_cnt;
   reg                       rst_meta;
   reg                       next_req_ready;
   reg                       next_cpl_valid;
   reg [`ECRP_DATA_W-1:0]    next_cpl_data;
   reg                       next_cpl_auto;
   reg                       next_read_received;
   reg                       next_write_received;
   reg [`ECRP_REG_W-1:0]     next_register_number;
   reg [`ECRP_FUNC_W-1:0]    next_function_number;
   reg [`ECRP_DATA_W-1:0]    next_write_data;
   reg [`ECRP_BE_W-1:0]      next_write_byte_enable;

   wire                      taken;
   wire [`ECRP_ADDR_W-1:0]   req_addr;
   wire                      in_leg_win;
   wire                      in_ext_win;
   wire                      fwd_write;
   wire                      fwd_read;
   wire                      user_read;
   wire                      timed_out;

   // =====================================================
   // request decode
   assign taken     = link_req_valid & link_req_ready;

   // register number counts dwords; windows are byte addresses
   assign req_addr  = {link_req_reg, 2'b00};

   assign in_leg_win = (req_addr >= `ECRP_LEG_LO) &&
                       (req_addr <= `ECRP_LEG_HI);
   assign in_ext_win = (req_addr >= `ECRP_EXT_LO) &&
                       (req_addr <= `ECRP_EXT_HI);

   // all writes are strobed when the option is on
   assign fwd_write = taken & link_req_write & ext_space_en;
   // all reads are strobed when the option is on, whatever their address
   assign fwd_read  = taken & ~link_req_write & ext_space_en;

   // only extended-window reads wait for the user to answer
   assign user_read = fwd_read & in_ext_win;

   assign timed_out = (wait_cnt == TIMEOUT_LAST);

   // =====================================================
   // user reset: asserts with arst_n, releases on a clock edge
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta   <= 1'b1;
         user_reset <= 1'b1;
      end else begin
         rst_meta   <= 1'b0;
         user_reset <= rst_meta;
      end
   end

   // =====================================================
   // next-state logic
   always @* begin
      next_state             = state;
      next_wait_cnt          = wait_cnt;
      next_cpl_valid         = 1'b0;
      next_cpl_data          = `ECRP_ZERO_DATA;
      next_cpl_auto          = 1'b0;
      next_read_received     = 1'b0;
      next_write_received    = 1'b0;
      next_register_number   = register_number;
      next_function_number   = function_number;
      next_write_data        = write_data;
      next_write_byte_enable = write_byte_enable;
      next_req_ready         = link_req_ready;

      case (state)
         ST_IDLE: begin
            if (taken) begin
               // fields latched once and held until the next request
               next_register_number = link_req_reg;
               next_function_number = link_req_func;
               if (link_req_write) begin
                  // every write carries its payload; window writes included
                  if (in_leg_win || in_ext_win || 1'b1) begin
                     next_write_data        = link_req_data;
                     next_write_byte_enable = link_req_be;
                  end
                  next_write_received = fwd_write;
               end else begin
                  next_read_received = fwd_read;
                  if (user_read) begin
                     // hold off new requests until the read completes
                     next_state     = `ECRP_ST_WAIT;
                     next_wait_cnt  = `ECRP_ZERO_CNT;
                     next_req_ready = 1'b0;
                  end else begin
                     // nobody outside answers this one: zero at once
                     next_cpl_valid = 1'b1;
                     next_cpl_data  = `ECRP_ZERO_DATA;
                  end
               end
            end
         end

         ST_WAIT: begin
            if (read_data_valid) begin
               // a late answer is still taken on the timeout cycle
               next_cpl_valid = 1'b1;
               next_cpl_data  = read_data;
               next_state     = `ECRP_ST_IDLE;
               next_req_ready = 1'b1;
            end else if (timed_out) begin
               next_cpl_valid = 1'b1;
               next_cpl_data  = `ECRP_ZERO_DATA;
               next_cpl_auto  = 1'b1;
               next_state     = `ECRP_ST_IDLE;
               next_req_ready = 1'b1;
            end else begin
               next_wait_cnt = wait_cnt + 1'b1;
            end
         end

         default: begin
            next_state     = `ECRP_ST_IDLE;
            next_req_ready = 1'b1;
         end
      endcase
   end

   // =====================================================
   // state and output registers
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state             <= `ECRP_ST_IDLE;
         wait_cnt          <= `ECRP_ZERO_CNT;
         link_req_ready    <= 1'b1;
         link_cpl_valid    <= 1'b0;
         link_cpl_data     <= `ECRP_ZERO_DATA;
         link_cpl_auto     <= 1'b0;
         read_received     <= 1'b0;
         write_received    <= 1'b0;
         register_number   <= `ECRP_ZERO_REG;
         function_number   <= `ECRP_ZERO_FUNC;
         write_data        <= `ECRP_ZERO_DATA;
         write_byte_enable <= `ECRP_ZERO_BE;
      end else begin
         state             <= next_state;
         wait_cnt          <= next_wait_cnt;
         link_req_ready    <= next_req_ready;
         link_cpl_valid    <= next_cpl_valid;
         link_cpl_data     <= next_cpl_data;
         link_cpl_auto     <= next_cpl_auto;
         read_received     <= next_read_received;
         write_received    <= next_write_received;
         register_number   <= next_register_number;
         function_number   <= next_function_number;
         write_data        <= next_write_data;
         write_byte_enable <= next_write_byte_enable;
      end
   end

endmodule

// File: tb/ecrp_port_sva.sv
// assertion checker for the external configuration register port
`timescale 1ns/1ps
module ecrp_port_sva #(
   parameter TIMEOUT_CYCLES = 16
) (
   // clock, reset, strap
   input logic        ref_clk, arst_n, ext_space_en,
   // link side
   input logic        link_req_valid, link_req_write, link_req_ready,
   input logic [9:0]  link_req_reg,
   input logic [31:0] link_req_data, link_cpl_data,
   input logic        link_cpl_valid, link_cpl_auto,
   // user side
   input logic        user_reset, read_received, write_received, read_data_valid,
   input logic [9:0]  register_number,
   input logic [31:0] write_data, read_data
);
   // =====
   // cycles spent waiting on the user
   logic [31:0] wait_n;
   wire         take = link_req_valid && link_req_ready;
   always @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
         wait_n <= 32'h0;
      else
         wait_n <= link_req_ready ? 32'h0 : wait_n + 32'h1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_rel; user_reset ##1 user_reset ##1 !user_reset; endsequence
   sequence s_pulse; read_received ##1 !read_received; endsequence
   property p_rst; $rose(arst_n) |-> s_rel; endproperty
   a_rst: assert property (p_rst) else $error("user reset release wrong");
   property p_wr; take && link_req_write && ext_space_en
      |=> write_received && write_data == $past(link_req_data); endproperty
   a_wr: assert property (p_wr) else $error("write not presented");
   property p_num; take && ext_space_en |=> register_number == $past(link_req_reg); endproperty
   a_num: assert property (p_num) else $error("register number wrong");
   property p_rd; take && !link_req_write && ext_space_en && link_req_reg >= 10'h3A0
      |=> s_pulse; endproperty
   a_rd: assert property (p_rd) else $error("read strobe not one cycle");
   property p_zero; take && !link_req_write && (!ext_space_en || link_req_reg < 10'h3A0)
      |=> link_cpl_valid && !link_cpl_auto && link_cpl_data == 32'h0; endproperty
   a_zero: assert property (p_zero) else $error("plain read not zero");
   property p_off; take && !ext_space_en |=> !read_received && !write_received; endproperty
   a_off: assert property (p_off) else $error("strobe with option off");
   property p_data; !link_req_ready && read_data_valid
      |=> link_cpl_valid && !link_cpl_auto && link_cpl_data == $past(read_data); endproperty
   a_data: assert property (p_data) else $error("user data not forwarded");
   property p_tmo; !link_req_ready && !read_data_valid && wait_n == TIMEOUT_CYCLES - 1
      |=> link_cpl_valid && link_cpl_auto && link_cpl_data == 32'h0; endproperty
   a_tmo: assert property (p_tmo) else $error("no auto response");
   property p_bnd; !link_req_ready |-> wait_n < TIMEOUT_CYCLES; endproperty
   a_bnd: assert property (p_bnd) else $error("wait too long");
endmodule
bind ecrp_port ecrp_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
   .ref_clk, .arst_n, .ext_space_en, .link_req_valid, .link_req_write, .link_req_ready,
   .link_req_reg, .link_req_data, .link_cpl_data, .link_cpl_valid, .link_cpl_auto,
   .user_reset, .read_received, .write_received, .read_data_valid, .register_number,
   .write_data, .read_data);

// File: tb/ecrp_user.sv
// user-side model answering extended configuration register reads with a pattern built from the register number
`timescale 1ns/1ps
module ecrp_user #(
   parameter TMO = 16
) (
   // clock, reset, answer delay
   input logic        ref_clk, arst_n,
   input int          dly,
   // port side
   input logic        read_received,
   input logic [9:0]  register_number,
   output logic [31:0] read_data,
   output logic       read_data_valid
);
   logic        busy;
   int          cnt;
   logic [31:0] resp;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         cnt <= 0;
         resp <= 32'h0F0F_0F0F;
      end else if (read_received && register_number >= 10'h3A0) begin
         busy <= 1'b1;
         cnt <= 1;
         resp <= {register_number, 22'h155555};
      end else if (busy && (read_data_valid || cnt >= TMO)) begin
         // request answered or abandoned: no stray answer afterwards
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt + 1;
      end
   end
   // gives up at the timeout so a late answer never follows the auto one
   assign read_data_valid = busy && cnt == dly && cnt < TMO;
   assign read_data = read_data_valid ? resp : ~resp;
endmodule

// File: tb/tb_ecrp_port.sv
// self-checking bench for the external configuration register port
`timescale 1ns/1ps
module tb_ecrp_port;
   logic ref_clk = 1'b0, arst_n = 1'b0, ext_space_en = 1'b1, link_req_valid = 1'b0;
   logic link_req_write = 1'b0, link_req_ready, link_cpl_valid, link_cpl_auto, user_reset;
   logic read_received, write_received, read_data_valid;
   logic [9:0]  link_req_reg = 10'h000, register_number;
   logic [7:0]  link_req_func = 8'h00, function_number;
   logic [31:0] link_req_data = 32'h0, link_cpl_data, write_data, read_data;
   logic [3:0]  link_req_be = 4'h0, write_byte_enable;
   int dly = 1, err_count = 0, comparisons = 0;
   initial forever #10 ref_clk = ~ref_clk;
   ecrp_port #(.TIMEOUT_CYCLES(16)) dut (.ref_clk, .arst_n, .ext_space_en, .link_req_valid,
      .link_req_write, .link_req_reg, .link_req_func, .link_req_data, .link_req_be,
      .link_req_ready, .link_cpl_valid, .link_cpl_data, .link_cpl_auto, .user_reset,
      .read_received, .write_received, .register_number, .function_number, .write_data,
      .write_byte_enable, .read_data, .read_data_valid);
   ecrp_user #(.TMO(16)) user (.ref_clk, .arst_n, .dly, .read_received, .register_number,
      .read_data, .read_data_valid);
   task print_verdict;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %0t: got %h want %h", $time, s, e);
      end
   endtask
   // =====
   // entered at a falling edge; returns in the cycle after the request is taken
   task req(input logic w, input logic [9:0] r);
      int i;
      link_req_valid = 1'b1;
      link_req_write = w;
      link_req_reg = r;
      link_req_func = r[9:2];
      link_req_data = {~r, r, 12'hC35};
      link_req_be = r[3:0];
      for (i = 0; i < 40 && link_req_ready !== 1'b1; i++) @(negedge ref_clk);
      if (i == 40) begin
         // a hang is a mismatch, never a pass
         err_count++;
         $display("CHECK FAILED %0t: request never accepted", $time);
         print_verdict;
      end
      @(negedge ref_clk);
      link_req_valid = 1'b0;
   endtask
   task rst;
      arst_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(user_reset, 1'b1);
      chk(link_req_ready, 1'b1);
      arst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(user_reset, 1'b0);
   endtask
   task wr(input logic [9:0] r, input logic s);
      req(1'b1, r);
      chk(write_received, s);
      if (s) begin
         chk(register_number, r);
         chk(function_number, r[9:2]);
         chk(write_data, {~r, r, 12'hC35});
         chk(write_byte_enable, r[3:0]);
      end
      @(negedge ref_clk);
      chk(write_received, 1'b0);
   endtask
   task rd(input logic [9:0] r, input logic s, input int d, input logic [31:0] ed,
           input logic ea, input int ek);
      int k;
      dly = d;
      req(1'b0, r);
      chk(read_received, s);
      if (s) begin
         chk(register_number, r);
         chk(function_number, r[9:2]);
      end
      for (k = 1; k < 40 && link_cpl_valid !== 1'b1; k++) @(negedge ref_clk);
      if (k == 40) begin
         err_count++;
         $display("CHECK FAILED %0t: read never completed", $time);
         print_verdict;
      end
      chk(k, ek);
      chk(link_cpl_data, ed);
      chk(link_cpl_auto, ea);
      @(negedge ref_clk);
   endtask
   task t_writes;
      wr(10'h02C, 1'b1);
      wr(10'h02F, 1'b1);
      wr(10'h3A0, 1'b1);
      wr(10'h3FF, 1'b1);
      wr(10'h39F, 1'b1);
   endtask
   task t_reads;
      rd(10'h3A0, 1'b1, 2, {10'h3A0, 22'h155555}, 1'b0, 4);
      rd(10'h3FF, 1'b1, 15, {10'h3FF, 22'h155555}, 1'b0, 17);
      rd(10'h3C0, 1'b1, 16, 32'h0, 1'b1, 17);
      rd(10'h02C, 1'b1, 1, 32'h0, 1'b0, 1);
   endtask
   task t_off;
      ext_space_en = 1'b0;
      wr(10'h3A0, 1'b0);
      rd(10'h3A0, 1'b0, 2, 32'h0, 1'b0, 1);
      ext_space_en = 1'b1;
   endtask
   initial begin
      rst;
      t_writes;
      t_reads;
      t_off;
      rst;
      t_reads;
      print_verdict;
   end
endmodule
